// file: hw/software_upset_timer.sv
`timescale 1ns/10ps
module software_upset_timer #(
  parameter int unsigned CLK_PER_OSC     = 1,
  parameter int unsigned OSC_PER_MACHINE = upset_timer_pkg::OSC_PER_MACHINE,
  parameter int unsigned PULSE_OSC       = upset_timer_pkg::PULSE_OSC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        osc_run_in,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // device side
  output logic             wd_enabled_out,
  output logic             rst_pin_out
);

  localparam int unsigned OSC_W  = $clog2(CLK_PER_OSC + 1);
  localparam int unsigned MACH_W = $clog2(OSC_PER_MACHINE + 1);
  localparam logic [OSC_W-1:0]  OSC_LAST  = OSC_W'(CLK_PER_OSC - 1);
  localparam logic [MACH_W-1:0] MACH_LAST = MACH_W'(OSC_PER_MACHINE - 1);
  localparam logic [OSC_W-1:0]  OSC_ONE   = OSC_W'(1);
  localparam logic [MACH_W-1:0] MACH_ONE  = MACH_W'(1);
  localparam logic [6:0]        PRE_ONE   = 7'h01;
  localparam int unsigned PULSE_CLKS = PULSE_OSC * CLK_PER_OSC;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  upset_timer_pkg::wd_state_t  wd_state_ff;
  upset_timer_pkg::key_write_t key_wr;
  upset_timer_pkg::reg_id_t    wr_id;
  upset_timer_pkg::reg_id_t    rd_id;

  logic [OSC_W-1:0]  osc_div_ff;
  logic [MACH_W-1:0] mach_div_ff;
  logic [6:0]        prescale_ff;
  logic [13:0]       count_ff;
  logic [2:0]        sel_ff;
  logic              ovf_seen_ff;
  logic              osc_tick;
  logic              mach_tick;
  logic              pre_tick;
  logic              service;
  logic              overflow;
  logic              pulse_abort;

  logic        aw_held_ff;
  logic        w_held_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        wr_fire;
  logic        ar_fire;
  logic [31:0] nxt_rdata;
  logic [1:0]  nxt_rresp;

  // ----------------------------------------------------------------
  // oscillator and machine cycle ticks
  // ----------------------------------------------------------------
  assign osc_tick  = osc_run_in && osc_div_ff == OSC_LAST;
  assign mach_tick = osc_tick && mach_div_ff == MACH_LAST;

  // machine cycles only pass while the oscillator runs
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      osc_div_ff <= '0;
    end else if (osc_run_in) begin
      osc_div_ff <= osc_tick ? '0 : osc_div_ff + OSC_ONE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mach_div_ff <= '0;
    end else if (osc_tick) begin
      mach_div_ff <= mach_tick ? '0 : mach_div_ff + MACH_ONE;
    end
  end

  // ----------------------------------------------------------------
  // prescaler: selection n advances the counter every 2^n cycles
  // ----------------------------------------------------------------
  assign pre_tick = mach_tick &&
                    ((prescale_ff & ((PRE_ONE << sel_ff) - PRE_ONE)) ==
                     ((PRE_ONE << sel_ff) - PRE_ONE));

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || wd_state_ff != upset_timer_pkg::WD_RUN) begin
      prescale_ff <= '0;
    end else if (service) begin
      prescale_ff <= '0;
    end else if (mach_tick) begin
      prescale_ff <= prescale_ff + PRE_ONE;
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter; no bus path reads or loads it
  // ----------------------------------------------------------------
  assign overflow = wd_state_ff == upset_timer_pkg::WD_RUN && pre_tick &&
                    count_ff == upset_timer_pkg::CNT_MAX && !service;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || wd_state_ff != upset_timer_pkg::WD_RUN) begin
      count_ff <= upset_timer_pkg::CNT_ZERO;
    end else if (service) begin
      count_ff <= upset_timer_pkg::CNT_ZERO;
    end else if (pre_tick) begin
      count_ff <= count_ff + upset_timer_pkg::CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // enable state: off, running, resetting
  // ----------------------------------------------------------------
  // nothing software writes can leave the running state
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wd_state_ff <= upset_timer_pkg::WD_OFF;
    end else begin
      case (wd_state_ff)
        upset_timer_pkg::WD_OFF: begin
          if (service) begin
            wd_state_ff <= upset_timer_pkg::WD_RUN;
          end
        end
        upset_timer_pkg::WD_RUN: begin
          if (overflow) begin
            wd_state_ff <= upset_timer_pkg::WD_PULSE;
          end
        end
        upset_timer_pkg::WD_PULSE: begin
          if (!rst_pin_out) begin
            wd_state_ff <= upset_timer_pkg::WD_OFF;
          end
        end
        default: begin
          wd_state_ff <= upset_timer_pkg::WD_OFF;
        end
      endcase
    end
  end

  // sticky record of a watchdog reset, cleared only by system reset
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ovf_seen_ff <= 1'b0;
    end else if (overflow) begin
      ovf_seen_ff <= 1'b1;
    end
  end

  assign wd_enabled_out = wd_state_ff == upset_timer_pkg::WD_RUN;
  assign pulse_abort    = wd_state_ff == upset_timer_pkg::WD_PULSE;

  // ----------------------------------------------------------------
  // key detection and reset pin
  // ----------------------------------------------------------------
  service_key_detect u_key (
    .clk_sys_in  (clk_sys_in),
    .sys_rst_in  (sys_rst_in),
    .abort_in    (pulse_abort),
    .key_wr_in   (key_wr),
    .service_out (service)
  );

  reset_pulse_gen #(
    .PULSE_CLKS (PULSE_CLKS)
  ) u_pulse (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (overflow),
    .pin_out    (rst_pin_out)
  );

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready_out = !aw_held_ff && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held_ff && !s_axi_bvalid_out;
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid_out;
  assign wr_id   = upset_timer_pkg::reg_decode(awaddr_ff);

  // address and data are caught in either order
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      w_held_ff <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata_in;
      wstrb_ff  <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  // only byte lane 0 carries register data
  // one driver for the whole struct: valid on top, the byte below it
  assign key_wr = {wr_fire && wstrb_ff[0] &&
                   wr_id == upset_timer_pkg::REG_SERVICE,
                   wdata_ff[7:0]};

  // prescale choice is taken only while the watchdog is off
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || pulse_abort) begin
      sel_ff <= upset_timer_pkg::SEL_RESET;
    end else if (wr_fire && wstrb_ff[0] &&
                 wr_id == upset_timer_pkg::REG_PRESCALE &&
                 wd_state_ff == upset_timer_pkg::WD_OFF) begin
      sel_ff <= wdata_ff[2:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= upset_timer_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= (wr_id == upset_timer_pkg::REG_NONE ||
                           wr_id == upset_timer_pkg::REG_STATUS) ?
                          upset_timer_pkg::RESP_SLVERR :
                          upset_timer_pkg::RESP_OKAY;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign rd_id   = upset_timer_pkg::reg_decode(s_axi_araddr_in);

  // service register reads zero; counter is not visible at all
  always_comb begin
    nxt_rdata = upset_timer_pkg::DATA_ZERO;
    nxt_rresp = upset_timer_pkg::RESP_OKAY;
    case (rd_id)
      upset_timer_pkg::REG_SERVICE: begin
        nxt_rdata = upset_timer_pkg::DATA_ZERO;
      end
      upset_timer_pkg::REG_PRESCALE: begin
        nxt_rdata[2:0] = sel_ff;
      end
      upset_timer_pkg::REG_STATUS: begin
        nxt_rdata[upset_timer_pkg::STAT_EN_BIT]  = wd_enabled_out;
        nxt_rdata[upset_timer_pkg::STAT_OVF_BIT] = ovf_seen_ff;
      end
      default: begin
        nxt_rresp = upset_timer_pkg::RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= upset_timer_pkg::DATA_ZERO;
      s_axi_rresp_out  <= upset_timer_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= nxt_rdata;
      s_axi_rresp_out  <= nxt_rresp;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule

// file: hw/upset_timer_pkg.sv
package upset_timer_pkg;

  // ----------------------------------------------------------------
  // counter and key values
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W     = 14;
  localparam logic [13:0] CNT_ZERO  = 14'h0000;
  localparam logic [13:0] CNT_ONE   = 14'h0001;
  localparam logic [13:0] CNT_MAX   = 14'h3FFF;
  localparam logic [7:0]  KEY_FIRST = 8'h1E;
  localparam logic [7:0]  KEY_LAST  = 8'hE1;
  localparam int unsigned PRE_W     = 7;
  localparam int unsigned SEL_W     = 3;
  localparam logic [2:0]  SEL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // oscillator and reset pin timing
  // ----------------------------------------------------------------
  localparam int unsigned OSC_PER_MACHINE = 12;
  localparam int unsigned PULSE_OSC       = 96;

  // ----------------------------------------------------------------
  // register map: printed offsets are indexes, byte address = 4 x index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 12;
  localparam logic [9:0]  IDX_SERVICE  = 10'h0A6;
  localparam logic [9:0]  IDX_PRESCALE = 10'h0A7;
  localparam logic [9:0]  IDX_STATUS   = 10'h0A8;
  localparam int unsigned STAT_EN_BIT  = 0;
  localparam int unsigned STAT_OVF_BIT = 1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WD_OFF   = 2'b00,
    WD_RUN   = 2'b01,
    WD_PULSE = 2'b11
  } wd_state_t;

  typedef enum logic {
    KEY_IDLE  = 1'b0,
    KEY_ARMED = 1'b1
  } key_state_t;

  typedef enum logic [1:0] {
    REG_NONE     = 2'h0,
    REG_SERVICE  = 2'h1,
    REG_PRESCALE = 2'h2,
    REG_STATUS   = 2'h3
  } reg_id_t;

  // one byte written to the service register
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } key_write_t;

  // decode a byte address into a register
  function automatic reg_id_t reg_decode(input logic [11:0] addr);
    reg_id_t id;
    id = REG_NONE;
    if (addr[11:2] == IDX_SERVICE) id = REG_SERVICE;
    else if (addr[11:2] == IDX_PRESCALE) id = REG_PRESCALE;
    else if (addr[11:2] == IDX_STATUS) id = REG_STATUS;
    return id;
  endfunction

endpackage

// file: hw/service_key_detect.sv
`timescale 1ns/10ps
module service_key_detect (
  input  wire logic                      clk_sys_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      abort_in,
  input  wire upset_timer_pkg::key_write_t key_wr_in,
  output logic                           service_out
);

  upset_timer_pkg::key_state_t key_state_ff;

  // ----------------------------------------------------------------
  // two byte key sequence
  // ----------------------------------------------------------------
  // a stray byte drops the half key, the first key byte re-arms
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || abort_in) begin
      key_state_ff <= upset_timer_pkg::KEY_IDLE;
    end else if (key_wr_in.valid) begin
      case (key_state_ff)
        upset_timer_pkg::KEY_IDLE: begin
          if (key_wr_in.data == upset_timer_pkg::KEY_FIRST) begin
            key_state_ff <= upset_timer_pkg::KEY_ARMED;
          end
        end
        upset_timer_pkg::KEY_ARMED: begin
          if (key_wr_in.data == upset_timer_pkg::KEY_FIRST) begin
            key_state_ff <= upset_timer_pkg::KEY_ARMED;
          end else begin
            key_state_ff <= upset_timer_pkg::KEY_IDLE;
          end
        end
        default: begin
          key_state_ff <= upset_timer_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  // one cycle pulse when the second byte follows the first
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || abort_in) begin
      service_out <= 1'b0;
    end else begin
      service_out <= key_wr_in.valid &&
                     key_state_ff == upset_timer_pkg::KEY_ARMED &&
                     key_wr_in.data == upset_timer_pkg::KEY_LAST;
    end
  end

endmodule

// file: hw/reset_pulse_gen.sv
`timescale 1ns/10ps
module reset_pulse_gen #(
  parameter int unsigned PULSE_CLKS = 96
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic start_in,
  output logic      pin_out
);

  localparam int unsigned CW = $clog2(PULSE_CLKS + 1);
  localparam logic [CW-1:0] LEN = CW'(PULSE_CLKS);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] left_ff;

  // ----------------------------------------------------------------
  // fixed length high pulse on the reset pin
  // ----------------------------------------------------------------
  // counts system clocks, so the length holds even if the
  // oscillator enable drops during the pulse
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      left_ff <= '0;
      pin_out <= 1'b0;
    end else if (start_in && left_ff == '0) begin
      left_ff <= LEN - ONE;
      pin_out <= 1'b1;
    end else if (left_ff != '0) begin
      left_ff <= left_ff - ONE;
      pin_out <= 1'b1;
    end else begin
      pin_out <= 1'b0;
    end
  end

endmodule

// file: test/upset_timer_checker.sv
`timescale 1ns/10ps
module upset_timer_checker #(
  parameter int unsigned CLK_PER_OSC = 1,
  parameter int unsigned PULSE_OSC   = 96
) (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic        s_axi_arready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        wd_enabled_out,
  input wire logic        rst_pin_out
);
  localparam int unsigned PULSE_CLKS = PULSE_OSC * CLK_PER_OSC;
  logic [13:0] on_cnt_ff;
  logic [15:0] hi_cnt_ff;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  // running cycles, saturating: a time-out can never come sooner
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !wd_enabled_out) on_cnt_ff <= 14'h0000;
    else if (on_cnt_ff != 14'h3FFF) on_cnt_ff <= on_cnt_ff + 14'h0001;
  end

  // cycles the reset pin has stood high so far
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !rst_pin_out) hi_cnt_ff <= 16'h0000;
    else hi_cnt_ff <= hi_cnt_ff + 16'h0001;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_reset_quiet: assert property (disable iff (1'b0)
    $fell(sys_rst_in) |-> !wd_enabled_out && !rst_pin_out)
    else $error("outputs active after reset");
  chk_on_holds: assert property (
    wd_enabled_out |=> wd_enabled_out || rst_pin_out)
    else $error("watchdog stopped without overflow");
  chk_pin_cause: assert property (
    $rose(rst_pin_out) |-> $past(wd_enabled_out))
    else $error("reset pulse while watchdog off");
  chk_pin_early: assert property (
    $rose(rst_pin_out) |-> on_cnt_ff == 14'h3FFF)
    else $error("reset pulse before full count");
  chk_pulse_len: assert property (
    $fell(rst_pin_out) && !$past(sys_rst_in) |-> hi_cnt_ff == PULSE_CLKS)
    else $error("reset pulse too short");
  chk_pulse_max: assert property (
    rst_pin_out |-> hi_cnt_ff < PULSE_CLKS)
    else $error("reset pulse too long");
  chk_off_after: assert property (
    $fell(rst_pin_out) |-> !wd_enabled_out)
    else $error("watchdog still on after pulse");
  chk_b_stands: assert property (
    s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  chk_r_stands: assert property (
    s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  chk_ar_refuse: assert property (
    s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address taken while busy");

  cover property ($rose(wd_enabled_out));
  cover property ($fell(rst_pin_out));
  cover property (s_axi_rvalid_out && s_axi_rready_in);
endmodule

bind software_upset_timer upset_timer_checker #(
  .CLK_PER_OSC(CLK_PER_OSC), .PULSE_OSC(PULSE_OSC)
) upset_timer_checker_i (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .s_axi_arready_out(s_axi_arready_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .wd_enabled_out(wd_enabled_out), .rst_pin_out(rst_pin_out)
);

// file: test/software_upset_timer_test.sv
`timescale 1ns/10ps
module software_upset_timer_test;
  localparam logic [11:0] A_SVC = {upset_timer_pkg::IDX_SERVICE, 2'b00};
  localparam logic [11:0] A_PRE = {upset_timer_pkg::IDX_PRESCALE, 2'b00};
  localparam logic [11:0] A_STA = {upset_timer_pkg::IDX_STATUS, 2'b00};
  localparam logic [1:0]  OK    = upset_timer_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR   = upset_timer_pkg::RESP_SLVERR;
  localparam int          PULSE_LEN = upset_timer_pkg::PULSE_OSC;
  logic        clk, rst, osc, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, wd_on, pin;
  logic        pin_seen;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  junk;
  logic [33:0] rexp;
  logic [1:0]  wq[$];
  logic [33:0] rq[$];
  int          bad_count, samples_checked, seed, n;

  software_upset_timer #(.OSC_PER_MACHINE(1)) software_upset_timer_i (
    .clk_sys_in(clk), .sys_rst_in(rst), .osc_run_in(osc),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .wd_enabled_out(wd_on), .rst_pin_out(pin));

  // ----------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s %h vs %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // first edge gap keeps bready from being driven twice in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    @(posedge clk);
    wq.push_back(r);
    awaddr  <= a;
    wdata   <= {24'($random(seed)), d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge clk);
    rq.push_back({r, d});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask

  task automatic svc();
    wr(A_SVC, upset_timer_pkg::KEY_FIRST, OK);
    wr(A_SVC, upset_timer_pkg::KEY_LAST, OK);
  endtask

  // edges from now until the pin rises, then the pulse width
  task automatic time_out(input int lo, hi);
    n = 0;
    while (!pin && n < hi) begin
      @(posedge clk);
      n++;
    end
    check(32'(n >= lo && n <= hi - 8), 32'h1, "time-out");
    n = 0;
    while (pin && n < 200) begin
      @(posedge clk);
      n++;
    end
    check(32'(n), 32'(PULSE_LEN), "pulse width");
    repeat (4) @(posedge clk);
    check(32'(wd_on), 32'h0, "off after pulse");
  endtask

  // ----------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // responses are matched against the oldest note
  always @(posedge clk) begin
    if (pin) pin_seen = 1'b1;
    if (bvalid && bready) check(32'(bresp), 32'(wq.pop_front()), "bresp");
    if (rvalid && rready) begin
      rexp = rq.pop_front();
      check(32'(rresp), 32'(rexp[33:32]), "rresp");
      if (rexp[33:32] === OK) check(rdata, rexp[31:0], "rdata");
    end
  end

  // longest path is about 85k cycles
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, pin_seen} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    wstrb = 4'hF;
    rst = 1'b1;
    osc = 1'b1;
    seed = 30;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(A_STA, 32'h0, OK);
    check(32'(wd_on), 32'h0, "off after reset");
    rd(A_SVC, 32'h0, OK);
    rd(12'h100, 32'h0, ERR);
    wr(A_STA, 8'h01, ERR);
    // broken keys leave the watchdog off
    junk = 8'($random(seed));
    if (junk == 8'h1E || junk == 8'hE1) junk = 8'h55;
    wr(A_SVC, 8'h1E, OK);
    wr(A_SVC, junk, OK);
    wr(A_SVC, 8'hE1, OK);
    wr(A_SVC, 8'hE1, OK);
    // a last byte outside byte lane 0 must not complete the key
    wr(A_SVC, 8'h1E, OK);
    wstrb <= 4'hE;
    wr(A_SVC, 8'hE1, OK);
    wstrb <= 4'hF;
    repeat (4) @(posedge clk);
    check(32'(wd_on), 32'h0, "bad key");
    // a repeated first byte keeps the key armed
    wr(A_SVC, 8'h1E, OK);
    svc();
    repeat (4) @(posedge clk);
    check(32'(wd_on), 32'h1, "enable");
    rd(A_STA, 32'h1, OK);
    // disable attempts are ignored
    wr(A_PRE, 8'h07, OK);
    wr(A_SVC, 8'h00, OK);
    repeat (4) @(posedge clk);
    check(32'(wd_on), 32'h1, "still on");
    rd(A_PRE, 32'h0, OK);
    // random then stopped oscillator: 18000 edges without overflow
    svc();
    pin_seen = 1'b0;
    repeat (12000) begin
      @(posedge clk);
      osc <= 1'($random(seed));
    end
    osc <= 1'b0;
    repeat (6000) @(posedge clk);
    osc <= 1'b1;
    svc();
    check(32'(pin_seen), 32'h0, "gated count");
    time_out(16380, 16408);
    rd(A_STA, 32'h2, OK);
    // longer selection doubles the time-out after each service
    wr(A_PRE, 8'h01, OK);
    rd(A_PRE, 32'h1, OK);
    svc();
    pin_seen = 1'b0;
    repeat (17000) @(posedge clk);
    svc();
    check(32'(pin_seen), 32'h0, "prescaled");
    time_out(32760, 32808);
    // reset in mid-run turns it off
    svc();
    repeat (2) @(posedge clk);
    check(32'(wd_on), 32'h1, "on before reset");
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(A_STA, 32'h0, OK);
    check(32'(wd_on), 32'h0, "off after reset");
    report_and_stop();
  end
endmodule
